/* File: hw/pcp_pkg.sv */
// Purpose: Constants and bus map for the dual-slope PWM stage
// Assumes: AHB-Lite single word transfers, 32-bit data
// Notes:   Offsets are byte addresses
package pcp_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CMP     = 8'h04;
    localparam logic [7:0] OFS_COUNT   = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0C;
    localparam logic [7:0] OFS_MASK    = 8'h10;
    // ****************************************
    // Control fields
    // ****************************************
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_MODE_LSB   = 1;
    localparam int CTRL_PRE_LSB    = 3;
    localparam int CTRL_DIR_BIT    = 6;
    localparam logic [1:0] MODE_NONINV = 2'h2;
    localparam logic [1:0] MODE_INV    = 2'h3;
    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam logic [7:0] CMP_RESET   = 8'h00;
    localparam logic [6:0] CTRL_RESET  = 7'h00;
    localparam int STEPS_PER_PERIOD = 510;
    localparam int PRE_MAX          = 1024;
    localparam int PRE_W            = 10;
    typedef enum logic [1:0] {
        PCP_BUS_IDLE,
        PCP_BUS_WRITE,
        PCP_BUS_READ
    } pcp_bus_t;
endpackage : pcp_pkg

/* File: hw/pcp_tick_if.sv */
// Purpose: Link between the prescaler and the waveform core
// Assumes: Single clock ref_clk
// Notes:   Carries select and the one-cycle tick
`timescale 1ns/1ps
interface pcp_tick_if;
    logic [2:0] sel;
    logic       run;
    logic       tick;
    modport core (output sel, output run, input tick);
    modport pre  (input sel, input run, output tick);
endinterface : pcp_tick_if

/* File: hw/pcp_prescaler.sv */
// Purpose: Prescale divider producing a one-cycle timer tick
// Assumes: Select codes 0..6 map to 1,8,32,64,128,256,1024
// Notes:   Codes 7 behave as divide by 1024
`timescale 1ns/1ps
module pcp_prescaler
    import pcp_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Tick link
    pcp_tick_if.pre  tk
);
    logic [PRE_W-1:0] div_cnt;
    function automatic logic [PRE_W-1:0] last_of(input logic [2:0] s);
        unique case (s)
            3'h0:    last_of = 10'h000;
            3'h1:    last_of = 10'h007;
            3'h2:    last_of = 10'h01F;
            3'h3:    last_of = 10'h03F;
            3'h4:    last_of = 10'h07F;
            3'h5:    last_of = 10'h0FF;
            default: last_of = 10'h3FF;
        endcase
    endfunction : last_of
    // Divider restarts when stopped so the first tick is a full N away
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt <= '0;
            tk.tick <= 1'b0;
        end else if (!tk.run) begin
            div_cnt <= '0;
            tk.tick <= 1'b0;
        end else if (div_cnt >= last_of(tk.sel)) begin
            div_cnt <= '0;
            tk.tick <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 10'h001;
            tk.tick <= 1'b0;
        end
    end
    // A select change inside the gap legally moves the next tick
    a_tick_single: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        tk.tick && tk.sel == 3'h1 && tk.run && $stable(tk.sel) |=>
        (!tk.tick || tk.sel != 3'h1) [*7])
        else $error("tick came early for divide by 8");
endmodule : pcp_prescaler

/* File: hw/pcp_pwm.sv */
// Purpose: 8-bit dual-slope PWM stage with AHB-Lite registers
// Assumes: One clock ref_clk at 25 MHz, async active-low nrst
// Notes:   Compare value is latched at MAX, as in a buffered update
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Counter steps on a prescaled tick of 1..1024, period N*510 clocks.
// - Non-inverted with compare at BOTTOM keeps the output low.
// - Non-inverted with compare at MAX keeps the output high.
// - Inverted mode gives the complement of both extreme cases.
// - The output may change at BOTTOM without any compare match.
// - Leaving MAX compare forces the up-match level at BOTTOM.
// - A missed up-count match is applied at BOTTOM instead.
// - The overflow flag sets each time the counter reaches BOTTOM.
// - Mode 2 is non-inverted, 3 inverted; pin driven only as output.
// - Up match clears, down match sets in non-inverted mode.
module pcp_pwm
    import pcp_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pin and interrupt
    output logic             waveform_output_pin,
    output logic             waveform_output_pin_oe,
    output logic             irq
);
    // ****************************************
    // Registers
    // ****************************************
    logic [6:0]  ctrl;
    logic [7:0]  compare_value_reg;
    logic [7:0]  cmp_live;
    logic [7:0]  counter_value;
    logic        count_down;
    logic        waveform_output;
    logic        overflow_flag;
    logic        irq_mask;
    logic [7:0]  a_addr;
    pcp_bus_t    bus_st;
    logic        at_bottom;
    logic        step_bottom;
    logic [1:0]  output_mode_field;
    logic        inv;
    logic        next_level;
    logic        clr_ovf;
    logic        cnt_load;
    pcp_tick_if  tk ();
    assign output_mode_field = ctrl[CTRL_MODE_LSB+:2];
    assign inv = (output_mode_field == MODE_INV);
    assign tk.sel = ctrl[CTRL_PRE_LSB+:3];
    assign tk.run = ctrl[CTRL_EN_BIT];
    pcp_prescaler i_pcp_prescaler (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tk      (tk)
    );
    // ****************************************
    // Bus slave
    // ****************************************
    // Zero wait states: every transfer answers in its first data cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bus_st <= PCP_BUS_IDLE;
            a_addr <= 8'h00;
        end else if (hready) begin
            a_addr <= haddr;
            if (hsel && htrans[1])
                bus_st <= hwrite ? PCP_BUS_WRITE : PCP_BUS_READ;
            else
                bus_st <= PCP_BUS_IDLE;
        end
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    // Read data registered at the address phase for a flopped output
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
                OFS_CTRL:   hrdata <= {25'h0, ctrl};
                OFS_CMP:    hrdata <= {24'h0, compare_value_reg};
                OFS_COUNT:  hrdata <= {24'h0, counter_value};
                OFS_STATUS: hrdata <= {31'h0, overflow_flag};
                OFS_MASK:   hrdata <= {31'h0, irq_mask};
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end
    assign clr_ovf = (bus_st == PCP_BUS_WRITE) &&
                     (a_addr == OFS_STATUS) && hwdata[0];
    assign cnt_load = (bus_st == PCP_BUS_WRITE) && (a_addr == OFS_COUNT);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl              <= CTRL_RESET;
            compare_value_reg <= CMP_RESET;
            irq_mask          <= 1'b0;
        end else if (bus_st == PCP_BUS_WRITE) begin
            unique case (a_addr)
                OFS_CTRL: ctrl              <= hwdata[6:0];
                OFS_CMP:  compare_value_reg <= hwdata[7:0];
                OFS_MASK: irq_mask          <= hwdata[0];
                default:  ;
            endcase
        end
    end
    // ****************************************
    // Counter
    // ****************************************
    assign at_bottom = tk.tick && count_down &&
                       (counter_value == 8'h01);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            counter_value <= CNT_BOTTOM;
            count_down    <= 1'b0;
        end else if (cnt_load) begin
            counter_value <= hwdata[7:0];
            count_down    <= 1'b0;
        end else if (tk.tick) begin
            if (!count_down && counter_value == CNT_MAX) begin
                counter_value <= counter_value - 8'h01;
                count_down    <= 1'b1;
            end else if (count_down && counter_value == 8'h01) begin
                counter_value <= CNT_BOTTOM;
                count_down    <= 1'b0;
            end else if (count_down) begin
                counter_value <= counter_value - 8'h01;
            end else begin
                counter_value <= counter_value + 8'h01;
            end
        end
    end
    // Compare value updates at MAX, keeping each period symmetric
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            cmp_live <= CMP_RESET;
        else if (!tk.run || (tk.tick && !count_down &&
                 counter_value == CNT_MAX))
            cmp_live <= compare_value_reg;
    end
    // ****************************************
    // Waveform
    // ****************************************
    // Level is a function of count and compare, so extremes and the
    // symmetric BOTTOM transition come out without special tracking
    function automatic logic pwm_level(input logic [7:0] c,
                                       input logic [7:0] cmp,
                                       input logic       i);
        logic hi;
        hi = (c < cmp) || (cmp == CNT_MAX);
        pwm_level = hi ^ i;
    endfunction : pwm_level
    assign step_bottom = at_bottom;
    // At BOTTOM the level of the new period is forced, covering a
    // compare leaving MAX and a missed up-count match
    always_comb begin
        next_level = waveform_output;
        if (step_bottom)
            next_level = pwm_level(CNT_BOTTOM, cmp_live, inv);
        else if (tk.tick)
            next_level = pwm_level(counter_value, cmp_live, inv);
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            waveform_output <= 1'b0;
        else if (output_mode_field[1])
            waveform_output <= next_level;
        else
            waveform_output <= 1'b0;
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            waveform_output_pin    <= 1'b0;
            waveform_output_pin_oe <= 1'b0;
        end else begin
            waveform_output_pin    <= waveform_output;
            waveform_output_pin_oe <= ctrl[CTRL_DIR_BIT] &&
                                      output_mode_field[1];
        end
    end
    // ****************************************
    // Flag and interrupt
    // ****************************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            overflow_flag <= 1'b0;
        else if (at_bottom)
            overflow_flag <= 1'b1;
        else if (clr_ovf)
            overflow_flag <= 1'b0;
    end
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= overflow_flag && irq_mask;
    end
    // ****************************************
    // Checks
    // ****************************************
    // Extreme-level checks look one clock back, at the tick cycle, so a mode or compare
    // change in flight is not mistaken for a wrong level
    sequence s_bottom_hit;
        at_bottom;
    endsequence
    sequence s_up_tick;
        tk.tick && !count_down;
    endsequence
    sequence s_down_tick;
        tk.tick && count_down;
    endsequence
    a_ovf_set: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_bottom_hit |=> overflow_flag)
        else $error("overflow flag missing after BOTTOM");
    a_flag_clear: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        clr_ovf && !at_bottom |=> !overflow_flag)
        else $error("overflow flag not cleared by write");
    a_low_zero: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        output_mode_field == MODE_NONINV && cmp_live == CNT_BOTTOM &&
        $past(output_mode_field) == MODE_NONINV &&
        $past(cmp_live) == CNT_BOTTOM && $past(tk.tick)
        |-> !waveform_output)
        else $error("output not low at compare BOTTOM");
    a_high_max: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        output_mode_field == MODE_NONINV && cmp_live == CNT_MAX &&
        $past(output_mode_field) == MODE_NONINV &&
        $past(cmp_live) == CNT_MAX && $past(tk.tick)
        |-> waveform_output)
        else $error("output not high at compare MAX");
    a_inv_zero: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        output_mode_field == MODE_INV && cmp_live == CNT_BOTTOM &&
        $past(output_mode_field) == MODE_INV &&
        $past(cmp_live) == CNT_BOTTOM && $past(tk.tick)
        |-> waveform_output)
        else $error("inverted output not high at BOTTOM");
    a_inv_max: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        output_mode_field == MODE_INV && cmp_live == CNT_MAX &&
        $past(output_mode_field) == MODE_INV &&
        $past(cmp_live) == CNT_MAX && $past(tk.tick)
        |-> !waveform_output)
        else $error("inverted output not low at MAX");
    a_bottom_lvl: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_bottom_hit ##0 (output_mode_field == MODE_NONINV &&
        cmp_live != CNT_BOTTOM) |=> waveform_output)
        else $error("BOTTOM level not forced to up-match result");
    a_up_clear: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_up_tick ##0 (output_mode_field == MODE_NONINV &&
        cmp_live != CNT_MAX && counter_value >= cmp_live)
        |=> !waveform_output)
        else $error("up-count match did not clear output");
    a_down_set: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_down_tick ##0 (output_mode_field == MODE_NONINV &&
        counter_value < cmp_live) |=> waveform_output)
        else $error("down-count match did not set output");
    a_inv_up: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_up_tick ##0 (output_mode_field == MODE_INV &&
        cmp_live != CNT_MAX && counter_value >= cmp_live)
        |=> waveform_output)
        else $error("inverted up-count match did not set output");
    a_turn_max: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_up_tick ##0 (counter_value == CNT_MAX && !cnt_load)
        |=> count_down && counter_value == 8'hFE)
        else $error("counter did not turn at MAX");
    a_turn_bottom: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        s_bottom_hit ##0 !cnt_load
        |=> !count_down && counter_value == CNT_BOTTOM)
        else $error("counter did not turn at BOTTOM");
    a_count_hold: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !tk.tick && !cnt_load |=> $stable(counter_value))
        else $error("counter moved without a tick");
    a_pin_oe: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !ctrl[CTRL_DIR_BIT] |=> !waveform_output_pin_oe)
        else $error("pin driven while direction is input");
    a_oe_on: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        ctrl[CTRL_DIR_BIT] && output_mode_field[1]
        |=> waveform_output_pin_oe)
        else $error("pin not driven in waveform mode");
    a_off_low: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !output_mode_field[1] |=> !waveform_output)
        else $error("output active with waveform mode off");
    a_pin_track: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> waveform_output_pin == $past(waveform_output))
        else $error("pin does not follow the waveform");
    a_irq_gate: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        overflow_flag && irq_mask |=> irq)
        else $error("unmasked overflow gave no interrupt");
    a_irq_quiet: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !(overflow_flag && irq_mask) |=> !irq)
        else $error("interrupt without unmasked overflow");
endmodule : pcp_pwm

/* File: verif/pcp_pin_load.sv */
// Purpose: Load on the PWM pin, with a pull-down and a duty counter
// Assumes: Released pin is pulled low by the load
// Notes:   Counter restarts on each rise of meas, counts high cycles while meas is high, then holds
`timescale 1ns/1ps
module pcp_pin_load (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    // Pin as seen from the board
    input  wire logic       pin,
    input  wire logic       pin_oe,
    // Measurement window
    input  wire logic       meas,
    output logic            line_level,
    output logic      [9:0] high_cycles
);
    logic meas_q;

    // Released pin must not keep its last level
    assign line_level = pin_oe ? pin : 1'b0;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meas_q      <= 1'b0;
            high_cycles <= 10'h000;
        end else begin
            meas_q <= meas;
            if (meas && !meas_q) begin
                high_cycles <= {9'h000, line_level};
            end else if (meas) begin
                high_cycles <= high_cycles + {9'h000, line_level};
            end
        end
    end
endmodule : pcp_pin_load

/* File: verif/pcp_pwm_tb.sv */
// Purpose: Self-checking bench for the dual-slope PWM stage
// Assumes: Zero-wait AHB-Lite slave, prescale code 0 steps every clock
// Notes:   Duty allows one step of skew from output registering
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    miscompares++; $display("wrong value at %0t: got %0h expected %0h", \
    $time, (a), (e)); end end
module pcp_pwm_tb
    import pcp_pkg::*;
;
    logic        ref_clk, nrst, hsel, hwrite, meas, hreadyout, hresp;
    logic        pin, pin_oe, irq, line_level;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [9:0]  high_cycles;
    int          miscompares, num_checks, cyc, hc, lo, hi, t1;
    logic [7:0]  cmps [6] = '{8'hFF, 8'h00, 8'h01, 8'h40, 8'h80, 8'hFE};
    logic [7:0]  ofs [6] = '{OFS_CTRL, OFS_CMP, OFS_COUNT, OFS_STATUS,
                             OFS_MASK, 8'h14};
    int          divs [3] = '{1, 8, 32};

    pcp_pwm i_pcp_pwm (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .waveform_output_pin(pin),
        .waveform_output_pin_oe(pin_oe), .irq(irq));
    pcp_pin_load i_pcp_pin_load (.ref_clk(ref_clk), .nrst(nrst),
        .pin(pin), .pin_oe(pin_oe), .meas(meas), .line_level(line_level),
        .high_cycles(high_cycles));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize  <= 3'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask : bus_rd

    function automatic logic [31:0] ctrl_word(logic [1:0] m,
                                              logic [2:0] p, logic d);
        ctrl_word = 32'h0000_0001 | ({30'h0, m} << CTRL_MODE_LSB)
                  | ({29'h0, p} << CTRL_PRE_LSB)
                  | ({31'h0, d} << CTRL_DIR_BIT);
    endfunction : ctrl_word

    // One full period of the load's duty counter
    task automatic measure(output int n);
        meas <= 1'b1;
        repeat (510) @(posedge ref_clk);
        meas <= 1'b0;
        @(posedge ref_clk);
        n = int'(high_cycles);
    endtask : measure

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // Hang guard, well above the expected run of about 63000 cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            print_verdict();
        end
    end

    initial begin
        {nrst, hsel, hwrite, meas} = 4'h0;
        {haddr, htrans, hsize, hwdata} = '0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        `CHK({pin_oe, irq, hresp, hreadyout}, 4'h1)
        foreach (ofs[i]) begin
            bus_rd(ofs[i], rd);
            `CHK(rd, 32'h0000_0000)
        end
        bus_wr(8'h14, 32'hFFFF_FFFF);
        bus_rd(8'h14, rd);
        `CHK(rd, 32'h0000_0000)
        // ****************************************
        // Pin gating by direction and mode
        // ****************************************
        bus_wr(OFS_CMP, 32'h0000_00FF);
        bus_rd(OFS_CMP, rd);
        `CHK(rd, 32'h0000_00FF)
        bus_wr(OFS_CTRL, ctrl_word(MODE_NONINV, 3'h0, 1'b0));
        repeat (1100) @(posedge ref_clk);
        `CHK({pin_oe, line_level}, 2'h0)
        bus_wr(OFS_CTRL, ctrl_word(2'h1, 3'h0, 1'b1));
        repeat (4) @(posedge ref_clk);
        `CHK({pin_oe, pin}, 2'h0)
        // ****************************************
        // Duty sweep, both polarities, MAX first
        // ****************************************
        for (int m = 0; m < 2; m++) begin
            foreach (cmps[i]) begin
                bus_wr(OFS_CMP, {24'h0, cmps[i]});
                bus_wr(OFS_CTRL, ctrl_word(m ? MODE_INV : MODE_NONINV,
                                           3'h0, 1'b1));
                repeat (1100) @(posedge ref_clk);
                measure(hc);
                lo = 2 * int'(cmps[i]);
                if (cmps[i] == CNT_MAX) lo = 510;
                if (m == 1) lo = 510 - lo;
                hi = lo;
                if (cmps[i] != CNT_MAX && cmps[i] != CNT_BOTTOM) begin
                    lo = lo - 1;
                    hi = hi + 1;
                end
                `CHK((hc >= lo && hc <= hi), 1'b1)
                `CHK(pin_oe, 1'b1)
            end
        end
        // ****************************************
        // Counter load above compare, missed up-match
        // ****************************************
        bus_wr(OFS_CTRL, 32'h0000_0000);
        bus_wr(OFS_CMP, 32'h0000_0040);
        bus_wr(OFS_COUNT, 32'h0000_00C0);
        bus_rd(OFS_COUNT, rd);
        `CHK(rd, 32'h0000_00C0)
        bus_wr(OFS_CTRL, ctrl_word(MODE_NONINV, 3'h0, 1'b1));
        repeat (20) @(posedge ref_clk);
        `CHK(pin, 1'b0)
        repeat (280) @(posedge ref_clk);
        `CHK(pin, 1'b1)
        // ****************************************
        // Overflow flag, mask and period length
        // ****************************************
        bus_wr(OFS_MASK, 32'h0000_0000);
        bus_wr(OFS_STATUS, 32'h0000_0001);
        repeat (600) @(posedge ref_clk);
        bus_rd(OFS_STATUS, rd);
        `CHK(rd, 32'h0000_0001)
        `CHK(irq, 1'b0)
        bus_wr(OFS_STATUS, 32'h0000_0001);
        bus_rd(OFS_STATUS, rd);
        `CHK(rd, 32'h0000_0000)
        bus_wr(OFS_MASK, 32'h0000_0001);
        foreach (divs[k]) begin
            bus_wr(OFS_CTRL, ctrl_word(MODE_NONINV, 3'(k), 1'b1));
            bus_wr(OFS_STATUS, 32'h0000_0001);
            // After the first pass the interrupt of the last period is still up here
            while (irq !== 1'b0) @(posedge ref_clk);
            while (irq !== 1'b1) @(posedge ref_clk);
            t1 = cyc;
            bus_wr(OFS_STATUS, 32'h0000_0001);
            while (irq !== 1'b0) @(posedge ref_clk);
            while (irq !== 1'b1) @(posedge ref_clk);
            `CHK(cyc - t1, 510 * divs[k])
        end
        print_verdict();
    end
endmodule : pcp_pwm_tb
